// >>> design/lmr_pkg.sv
// constants and carrier types for the line mode register bank
package lmr_pkg;

   // ***********************************************
   // register word indexes (byte address = 4 * index)
   // ***********************************************
   localparam logic [9:0] LMR_IDX_SIGNATURE = 10'h000;
   localparam logic [9:0] LMR_IDX_SOFT_RST  = 10'h004;
   localparam logic [9:0] LMR_IDX_PM_PORT   = 10'h00e;
   localparam logic [9:0] LMR_IDX_PM_DATA   = 10'h00f;
   localparam logic [9:0] LMR_IDX_MODE1     = 10'h020;
   localparam logic [9:0] LMR_IDX_MODE2     = 10'h120;
   localparam logic [9:0] LMR_IDX_IND_SEL   = 10'h040;
   localparam logic [9:0] LMR_IDX_IND_DATA  = 10'h041;

   // ***********************************************
   // line mode register fields
   // ***********************************************
   localparam int         LMR_MODE_STD_BIT = 0;
   localparam int         LMR_MODE_FMT_LSB = 1;
   localparam int         LMR_MODE_JP_BIT  = 3;
   localparam logic [7:0] LMR_MODE_MASK    = 8'h0f;
   localparam logic [7:0] LMR_MODE_RST     = 8'h00;

   typedef enum logic [1:0] {
      LMR_FMT_SF  = 2'h0,
      LMR_FMT_ESF = 2'h1,
      LMR_FMT_DM  = 2'h2,
      LMR_FMT_SLC = 2'h3
   } lmr_fmt_t;

   // ***********************************************
   // counter access port and indirect window fields
   // ***********************************************
   localparam int         LMR_PM_LINK_BIT  = 6;
   localparam logic [7:0] LMR_PM_PORT_MASK = 8'h4f;
   localparam logic [7:0] LMR_PM_PORT_RST  = 8'h00;
   localparam int         LMR_IND_LINK_BIT = 7;
   localparam int         LMR_IND_SPC_LSB  = 8;
   localparam logic [9:0] LMR_IND_SEL_RST  = 10'h000;
   localparam int         LMR_IND_DEPTH    = 96;

   typedef enum logic [1:0] {
      LMR_SPC_EXTRACT = 2'h0,
      LMR_SPC_RX_COND = 2'h1,
      LMR_SPC_TX_COND = 2'h2
   } lmr_spc_t;

   // ***********************************************
   // carriers
   // ***********************************************
   typedef struct packed {
      logic [9:0]  crc_error_count;
      logic [11:0] framing_bit_error_count;
      logic [2:0]  frame_alignment_change_count;
      logic [4:0]  out_of_frame_count;
      logic [15:0] pattern_checker_error_count;
      logic [15:0] line_code_violation_count;
      logic [9:0]  transmit_crc_report_count;
      logic [9:0]  far_end_block_error_count;
      logic [9:0]  transmit_far_block_error_count;
   } lmr_performance_counters_t;

   typedef struct packed {
      logic     t1j1_family;
      logic     j1_variant;
      lmr_fmt_t frame_format;
      logic     format_valid;
   } lmr_mode_t;

endpackage

// >>> design/lmr_bank.sv
// apb register bank: line mode, signature, soft reset, indirect maps
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps

//Operation
// - mode bit 0 picks E1 when 0, JAPAN_VARIANT_SELECT family when 1
// - variant bit picks T1 or J1, ignored in E1
// - two-bit format field: SF, ESF, DM, SLC-96, unused in E1
// - DM and SLC-96 honoured only in T1; software avoids them in J1
// - mode fields reset to zero, link starts in E1
// - single-address registers are global, address pairs per link
// - signature is read-only: device code high nibble, revision low
// - any write to soft reset register triggers a soft reset
// - soft reset acts only while the reference clock runs
// - soft reset restores defaults everywhere except mode registers
// - crc count: low byte at even address, bits 9:8 next
// - framing bit count: low byte at 02, bits 11:8 at 03
// - pattern checker count: low byte at 06, high at 07
// - line code violation count: low byte 08, high 09
// - far-end block counts: low byte even, bits 9:8 odd
// - extractor entries per signaling slot: enable bit 4, ABCD 3:0
// - conditioners hold per-slot control byte for slots 0 to 31
// - conditioners hold idle data code bytes at 20 to 3F
// - conditioner signaling entries: test bit 6, force bit 4, ABCD
// - counter bytes read via link/address port and data register
module lmr_bank
   import lmr_pkg::*;
#(
   parameter int         P_ADDR_W   = 12,
   parameter logic [3:0] P_DEV_CODE = 4'ha, // arbitrary value
   parameter logic [3:0] P_REVISION = 4'h5  // arbitrary value
)
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [P_ADDR_W-1:0]   i_paddr,
   input  wire logic [31:0]           i_pwdata,
   input  wire logic [3:0]            i_pstrb,
   output logic                       o_pready,
   output logic                       o_pslverr,
   output logic [31:0]                o_prdata,
   input  wire lmr_pkg::lmr_performance_counters_t    i_pmon1,
   input  wire lmr_pkg::lmr_performance_counters_t    i_pmon2,
   output lmr_pkg::lmr_mode_t         o_mode1,
   output lmr_pkg::lmr_mode_t         o_mode2,
   output logic                       o_soft_reset
);
   import lmr_pkg::*;

   // refused at elaboration: the decode needs the full 12-bit byte address, word index from bits 11:2
   if (P_ADDR_W < 12)
   begin : g_addr_w_check
      $error("lmr_bank: P_ADDR_W must be at least 12");
   end

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic lmr_mode_t decode_mode(input logic [7:0] r);
      lmr_mode_t m;
      m.t1j1_family  = r[LMR_MODE_STD_BIT];
      m.j1_variant   = r[LMR_MODE_STD_BIT] & r[LMR_MODE_JP_BIT];
      m.frame_format = lmr_fmt_t'(r[LMR_MODE_FMT_LSB +: 2]);
      // DM and SLC-96 only stand in plain T1; the flag drops otherwise
      m.format_valid = r[LMR_MODE_STD_BIT]
                       & ~(r[LMR_MODE_JP_BIT] & r[LMR_MODE_FMT_LSB+1]);
      return m;
   endfunction

   function automatic logic [7:0] performance_counters_byte(input lmr_performance_counters_t p,
                                            input logic [3:0] a);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         4'h0: b = p.crc_error_count[7:0];
         4'h1: b = {6'h00, p.crc_error_count[9:8]};
         4'h2: b = p.framing_bit_error_count[7:0];
         4'h3: b = {4'h0, p.framing_bit_error_count[11:8]};
         4'h4: b = {5'h00, p.frame_alignment_change_count};
         4'h5: b = {3'h0, p.out_of_frame_count};
         4'h6: b = p.pattern_checker_error_count[7:0];
         4'h7: b = p.pattern_checker_error_count[15:8];
         4'h8: b = p.line_code_violation_count[7:0];
         4'h9: b = p.line_code_violation_count[15:8];
         4'ha: b = p.transmit_crc_report_count[7:0];
         4'hb: b = {6'h00, p.transmit_crc_report_count[9:8]};
         4'hc: b = p.far_end_block_error_count[7:0];
         4'hd: b = {6'h00, p.far_end_block_error_count[9:8]};
         4'he: b = p.transmit_far_block_error_count[7:0];
         4'hf: b = {6'h00, p.transmit_far_block_error_count[9:8]};
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // bits that exist at an indirect address; zero marks a hole
   function automatic logic [7:0] ind_mask(input logic [1:0] s,
                                           input logic [6:0] a);
      logic [7:0] m;
      m = 8'h00;
      if (s == LMR_SPC_EXTRACT)
      begin
         // slots 1-15 and 17-31, enable plus ABCD
         if (a[6:5] == 2'h0 && a[3:0] != 4'h0)
            m = 8'h1f;
      end
      else if (s == LMR_SPC_RX_COND || s == LMR_SPC_TX_COND)
      begin
         // control bytes 00-1F, idle codes 20-3F
         if (a[6] == 1'b0)
            m = 8'hff;
         else if (a[5] == 1'b0 && a[3:0] != 4'h0)
            m = 8'h5f;
      end
      return m;
   endfunction

   // ***********************************************
   // apb decode
   // ***********************************************
   wire logic [9:0] word_idx  = i_paddr[11:2];
   wire logic       setup_ph  = i_psel & ~i_penable;
   wire logic       access_ph = i_psel & i_penable;
   wire logic       hit_sig   = (word_idx == LMR_IDX_SIGNATURE);
   wire logic       hit_srst  = (word_idx == LMR_IDX_SOFT_RST);
   wire logic       hit_pport = (word_idx == LMR_IDX_PM_PORT);
   wire logic       hit_pdata = (word_idx == LMR_IDX_PM_DATA);
   wire logic       hit_mode1 = (word_idx == LMR_IDX_MODE1);
   wire logic       hit_mode2 = (word_idx == LMR_IDX_MODE2);
   wire logic       hit_isel  = (word_idx == LMR_IDX_IND_SEL);
   wire logic       hit_idata = (word_idx == LMR_IDX_IND_DATA);
   wire logic       upper_ok  = (P_ADDR_W == 12) ? 1'b1
                                : (i_paddr >> 12) == '0;
   wire logic       hit_any   = upper_ok & (hit_sig | hit_srst
                                | hit_pport | hit_pdata | hit_mode1
                                | hit_mode2 | hit_isel | hit_idata);
   wire logic       wr_acc    = access_ph & i_pwrite & hit_any;
   // the byte-wide registers take lane 0 only; the indirect select also takes lane 1
   wire logic       wr_lane0  = wr_acc & i_pstrb[0];
   wire logic [7:0] wbyte     = i_pwdata[7:0];

   assign o_pready  = 1'b1;
   assign o_pslverr = access_ph & ~hit_any;

   // ***********************************************
   // soft reset
   // ***********************************************
   // any write, data and strobes ignored
   wire logic soft_rst_wr = wr_acc & hit_srst;

   // pulse is clocked, so it needs the reference clock
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_soft_reset <= 1'b0;
      else
         o_soft_reset <= soft_rst_wr;
   end

   // ***********************************************
   // per-link line mode registers
   // ***********************************************
   logic [7:0] mode1;
   logic [7:0] mode2;

   // one copy per link, reserved bits dropped
   wire logic [7:0] next_mode1 = (wr_lane0 & hit_mode1)
                                 ? (wbyte & LMR_MODE_MASK) : mode1;
   wire logic [7:0] next_mode2 = (wr_lane0 & hit_mode2)
                                 ? (wbyte & LMR_MODE_MASK) : mode2;

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         mode1 <= LMR_MODE_RST;
         mode2 <= LMR_MODE_RST;
      end
      else
      begin
         mode1 <= next_mode1;
         mode2 <= next_mode2;
      end
   end

   assign o_mode1 = decode_mode(mode1);
   assign o_mode2 = decode_mode(mode2);

   // ***********************************************
   // counter access port
   // ***********************************************
   logic [7:0] pm_port;

   wire logic [7:0] next_pm_port = (wr_lane0 & hit_pport)
                                   ? (wbyte & LMR_PM_PORT_MASK)
                                   : pm_port;

   // global registers return to defaults on soft reset
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         pm_port <= LMR_PM_PORT_RST;
      else if (soft_rst_wr)
         pm_port <= LMR_PM_PORT_RST;
      else
         pm_port <= next_pm_port;
   end

   // selected link and address pick the byte
   wire logic [7:0] pm_byte = pm_port[LMR_PM_LINK_BIT]
                              ? performance_counters_byte(i_pmon2, pm_port[3:0])
                              : performance_counters_byte(i_pmon1, pm_port[3:0]);

   // ***********************************************
   // indirect maps: extractor and two conditioners
   // ***********************************************
   logic [9:0] ind_sel;
   logic [7:0] ind_mem [0:1][0:2][0:LMR_IND_DEPTH-1];

   wire logic       ind_link = ind_sel[LMR_IND_LINK_BIT];
   wire logic [1:0] ind_spc  = ind_sel[LMR_IND_SPC_LSB +: 2];
   wire logic [6:0] ind_addr = ind_sel[6:0];
   wire logic [7:0] ind_bits = ind_mask(ind_spc, ind_addr);
   // a zero mask also keeps the array index in range
   wire logic       ind_ok   = (ind_bits != 8'h00);
   wire logic       ind_wr   = wr_lane0 & hit_idata & ind_ok;
   wire logic [7:0] ind_rd   = ind_ok
      ? (ind_mem[ind_link][ind_spc][ind_addr] & ind_bits) : 8'h00;

   wire logic [9:0] next_ind_sel = (wr_acc & hit_isel)
                                   ? {i_pwdata[9:8] & {2{i_pstrb[1]}},
                                      i_pwdata[7:0] & {8{i_pstrb[0]}}}
                                   : ind_sel;

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         ind_sel <= LMR_IND_SEL_RST;
      else if (soft_rst_wr)
         ind_sel <= LMR_IND_SEL_RST;
      else
         ind_sel <= next_ind_sel;
   end

   // soft reset clears every entry back to zero
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int l = 0; l < 2; l++)
            for (int s = 0; s < 3; s++)
               for (int a = 0; a < LMR_IND_DEPTH; a++)
                  ind_mem[l][s][a] <= 8'h00;
      end
      else if (soft_rst_wr)
      begin
         for (int l = 0; l < 2; l++)
            for (int s = 0; s < 3; s++)
               for (int a = 0; a < LMR_IND_DEPTH; a++)
                  ind_mem[l][s][a] <= 8'h00;
      end
      else if (ind_wr)
         ind_mem[ind_link][ind_spc][ind_addr] <= wbyte & ind_bits;
   end

   // ***********************************************
   // read data, captured in the setup cycle
   // ***********************************************
   // fixed signature
   wire logic [7:0] sig_byte = {P_DEV_CODE, P_REVISION};

   // soft reset register and holes read as zero
   wire logic [9:0] rd_word =
      hit_sig   ? {2'h0, sig_byte} :
      hit_pport ? {2'h0, pm_port}  :
      hit_pdata ? {2'h0, pm_byte}  :
      hit_mode1 ? {2'h0, mode1}    :
      hit_mode2 ? {2'h0, mode2}    :
      hit_isel  ? ind_sel          :
      hit_idata ? {2'h0, ind_rd}   : 10'h000;

   // capturing at setup keeps prdata a flop; pready needs no wait
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_prdata <= 32'h0000_0000;
      else if (setup_ph & ~i_pwrite)
         o_prdata <= {22'h0, rd_word & {10{upper_ok}}};
   end

endmodule // lmr_bank

// >>> sim/lmr_bank_checker.sv
// assertions on the ports of the line mode register bank
`timescale 1ns/100ps
module lmr_bank_checker
   import lmr_pkg::*;
#(
   parameter int         P_ADDR_W   = 12,
   parameter logic [3:0] P_DEV_CODE = 4'ha,
   parameter logic [3:0] P_REVISION = 4'h5
)
(
   input wire logic                i_clk_sys,
   input wire logic                i_rst,
   input wire logic                i_psel,
   input wire logic                i_penable,
   input wire logic                i_pwrite,
   input wire logic [P_ADDR_W-1:0] i_paddr,
   input wire logic [31:0]         i_pwdata,
   input wire logic [3:0]          i_pstrb,
   input wire logic                o_pready,
   input wire logic                o_pslverr,
   input wire logic [31:0]         o_prdata,
   input wire lmr_pkg::lmr_mode_t  o_mode1,
   input wire lmr_pkg::lmr_mode_t  o_mode2,
   input wire logic                o_soft_reset
);
   wire logic rd_acc = i_psel & i_penable & ~i_pwrite;
   wire logic wr_acc = i_psel & i_penable & i_pwrite;
   wire logic at_sig = i_paddr == P_ADDR_W'(12'h000);
   wire logic at_sr  = i_paddr == P_ADDR_W'(12'h010);
   wire logic at_m1  = i_paddr == P_ADDR_W'(12'h080);

   // ***********************************************
   // properties
   // ***********************************************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   property p_mode_load;
      wr_acc && at_m1 && i_pstrb[0] |=> o_mode1.t1j1_family == $past(
         i_pwdata[0]) && o_mode1.frame_format == $past(i_pwdata[2:1]);
   endproperty
   a_mode_load: assert property (p_mode_load)
      else $error("mode1 output does not follow the write");
   property p_mode_other;
      wr_acc && at_m1 |=> $stable(o_mode2);
   endproperty
   a_mode_other: assert property (p_mode_other)
      else $error("link2 mode moved on a link1 write");
   property p_variant;
      !(o_mode1.j1_variant && !o_mode1.t1j1_family) &&
      !(o_mode2.j1_variant && !o_mode2.t1j1_family);
   endproperty
   a_variant: assert property (p_variant)
      else $error("variant active outside the japan_variant_select family");
   property p_fmt_valid;
      o_mode2.format_valid == (o_mode2.t1j1_family && !(o_mode2.j1_variant
         && o_mode2.frame_format inside {LMR_FMT_DM, LMR_FMT_SLC}));
   endproperty
   a_fmt_valid: assert property (p_fmt_valid)
      else $error("format valid flag wrong");
   property p_sr_pulse;
      wr_acc && at_sr |=> o_soft_reset ##1 !o_soft_reset;
   endproperty
   a_sr_pulse: assert property (p_sr_pulse)
      else $error("soft reset pulse missing or too long");
   property p_sr_cause;
      o_soft_reset |-> $past(wr_acc && at_sr);
   endproperty
   a_sr_cause: assert property (p_sr_cause)
      else $error("soft reset without a write");
   property p_sr_keep;
      o_soft_reset |-> $stable(o_mode1) && $stable(o_mode2);
   endproperty
   a_sr_keep: assert property (p_sr_keep)
      else $error("soft reset disturbed a mode register");
   property p_sig_read;
      rd_acc && at_sig |-> o_prdata == {24'h0, P_DEV_CODE, P_REVISION};
   endproperty
   a_sig_read: assert property (p_sig_read)
      else $error("signature read wrong");
   property p_mode_read;
      rd_acc && at_m1 |-> o_prdata[31:4] == 28'h0 &&
         o_prdata[0] == o_mode1.t1j1_family &&
         (o_prdata[3] & o_prdata[0]) == o_mode1.j1_variant &&
         o_prdata[2:1] == o_mode1.frame_format;
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("mode1 read back wrong");
   property p_sr_read;
      rd_acc && at_sr |-> o_prdata == 32'h0;
   endproperty
   a_sr_read: assert property (p_sr_read)
      else $error("soft reset register not read as zero");
   c_sr: cover property (o_soft_reset);
   c_dm: cover property (o_mode1.j1_variant && !o_mode1.format_valid);
   c_err: cover property (o_pslverr);
endmodule // lmr_bank_checker

bind lmr_bank lmr_bank_checker #(.P_ADDR_W(P_ADDR_W),
   .P_DEV_CODE(P_DEV_CODE), .P_REVISION(P_REVISION)) i_lmr_bank_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_mode1(o_mode1),
   .o_mode2(o_mode2), .o_soft_reset(o_soft_reset));

// >>> sim/tb_top.sv
// self-checking bench for the line mode register bank
`timescale 1ns/100ps
module tb_top;
   import lmr_pkg::*;
   localparam logic [3:0] DEV = 4'h3; // arbitrary value
   localparam logic [3:0] REV = 4'h9; // arbitrary value
   logic        clk, rst, psel, pen, pwr, rdy, err, srst, perr;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, seed, r;
   logic [95:0] rv;
   lmr_performance_counters_t   pm1, pm2;
   lmr_mode_t   md1, md2;
   logic [3:0]  mm [2];
   int          mismatches, checks;
   // space, link and entry address, writable mask
   logic [17:0] tbl [13] = '{18'h0051f, 18'h09000, 18'h09f1f, 18'h02000,
      18'h00000, 18'h100ff, 18'h13fff, 18'h1c55f, 18'h14000, 18'h29fff,
      18'h2515f, 18'h2d000, 18'h30500};

   lmr_bank #(.P_DEV_CODE(DEV), .P_REVISION(REV)) i_lmr_bank (
      .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(4'hf),
      .o_pready(rdy), .o_pslverr(err), .o_prdata(prd), .i_pmon1(pm1),
      .i_pmon2(pm2), .o_mode1(md1), .o_mode2(md2), .o_soft_reset(srst));

   // ***********************************************
   // models and bus tasks
   // ***********************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] pm_byte(input lmr_performance_counters_t p,
                                          input logic [3:0] a);
      logic [127:0] m;
      m = {6'h0, p.transmit_far_block_error_count, 6'h0,
         p.far_end_block_error_count, 6'h0, p.transmit_crc_report_count,
         p.line_code_violation_count, p.pattern_checker_error_count, 3'h0,
         p.out_of_frame_count, 5'h0, p.frame_alignment_change_count, 4'h0,
         p.framing_bit_error_count, 6'h0, p.crc_error_count};
      return m[a*8 +: 8];
   endfunction

   // variant only counts in the japan_variant_select family, dm and slc only in plain t1
   function automatic lmr_mode_t exp_mode(input logic [3:0] m);
      return {m[0], m[0] & m[3], m[2:1], m[0] & ~(m[3] & m[2])};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clk);
      end
      if (n >= 50)
      begin
         mismatches++;
         conclude();
      end
      r = prd;
      perr = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(r, exp);
   endtask

   // ***********************************************
   // stimulus
   // ***********************************************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h0;
      pwd = 32'h0;
      mismatches = 0;
      checks = 0;
      mm = '{4'h0, 4'h0};
      seed = 32'hf5c0;
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         rv[i*32 +: 32] = seed;
      end
      pm1 = rv[91:0];
      pm2 = rv[95:4];
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(12'h000, {24'h0, DEV, REV});
      rdc(12'h080, 32'h0);
      rdc(12'h480, 32'h0);
      check({27'h0, md1}, 32'h0);
      wr(12'h000, 32'hff);
      rdc(12'h000, {24'h0, DEV, REV});
      // both modes set before other registers
      for (int l = 0; l < 2; l++)
         for (int v = 0; v < 16; v++)
         begin
            seed = lfsr(seed);
            wr(l ? 12'h480 : 12'h080, {seed[31:4], v[3:0]});
            mm[l] = v[3:0];
            rdc(l ? 12'h480 : 12'h080, {28'h0, v[3:0]});
            rdc(l ? 12'h080 : 12'h480, {28'h0, mm[1-l]});
            check({27'h0, md1}, {27'h0, exp_mode(mm[0])});
            check({27'h0, md2}, {27'h0, exp_mode(mm[1])});
         end
      for (int a = 0; a < 32; a++)
      begin
         wr(12'h038, {25'h0, a[4], 2'h0, a[3:0]});
         rdc(12'h03c, {24'h0, pm_byte(a[4] ? pm2 : pm1, a[3:0])});
      end
      foreach (tbl[i])
      begin
         seed = lfsr(seed);
         wr(12'h100, {22'h0, tbl[i][17:8]});
         wr(12'h104, seed);
         rdc(12'h104, {24'h0, seed[7:0] & tbl[i][7:0]});
      end
      // counter port change is followed by a soft reset
      wr(12'h038, 32'h4f);
      seed = lfsr(seed);
      wr(12'h010, seed);
      // look between edges so the pulse is settled when sampled
      @(negedge clk);
      check({31'h0, srst}, 32'h1);
      @(negedge clk);
      check({31'h0, srst}, 32'h0);
      rdc(12'h038, 32'h0);
      rdc(12'h080, {28'h0, mm[0]});
      rdc(12'h480, {28'h0, mm[1]});
      rdc(12'h010, 32'h0);
      wr(12'h100, 32'h13f);
      rdc(12'h104, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      check({31'h0, perr}, 32'h1);
      conclude();
   end
endmodule // tb_top
